// ### inc/vsd_pkg.sv
package vsd_pkg;
  // Storage depth and register bookkeeping of the system control unit
  localparam int          TLB_DEPTH      = 64;
  localparam int          TLB_IDX_W      = 6;
  localparam int          SCU_REG_COUNT  = 27;
  localparam logic [4:0]  REGNUM_LO0     = 5'h02;
  localparam logic [4:0]  REGNUM_LO1     = 5'h03;
  localparam logic [4:0]  REGNUM_MASK    = 5'h05;
  localparam logic [4:0]  REGNUM_TAG     = 5'h0A;
  // Wishbone byte offsets, one 32-bit word each
  localparam logic [7:0]  OFS_MASK       = 8'h00;
  localparam logic [7:0]  OFS_TAG_LO     = 8'h08;
  localparam logic [7:0]  OFS_TAG_HI     = 8'h0C;
  localparam logic [7:0]  OFS_LO0_LO     = 8'h10;
  localparam logic [7:0]  OFS_LO0_HI     = 8'h14;
  localparam logic [7:0]  OFS_LO1_LO     = 8'h18;
  localparam logic [7:0]  OFS_LO1_HI     = 8'h1C;
  localparam logic [7:0]  OFS_CMD        = 8'h20;
  localparam logic [7:0]  OFS_MODE       = 8'h24;
  localparam logic [7:0]  OFS_CFG        = 8'h28;
  localparam logic [7:0]  OFS_RESULT     = 8'h2C;
  // Writable bits of each staging register; all else reads as zero
  localparam logic [31:0] MASK_WMASK     = 32'h01FF_E000;
  localparam logic [63:0] TAG_WMASK      = 64'hC000_00FF_FFFF_E0FF;
  localparam logic [63:0] LO_WMASK       = 64'h0000_0000_3FFF_FFFF;
  // Field positions
  localparam int          MASK_LSB       = 13;
  localparam int          VPN_LSB        = 13;
  localparam int          PFN_LSB        = 6;
  localparam int          C_LSB          = 3;
  localparam int          D_BIT          = 2;
  localparam int          V_BIT          = 1;
  localparam int          G_BIT          = 0;
  localparam int          KSU_LSB        = 3;
  localparam int          ERL_BIT        = 2;
  localparam int          EXL_BIT        = 1;
  localparam int          CMD_WR_BIT     = 31;
  // Reset values: start in error level so the core boots in kernel mode
  localparam logic [4:0]  MODE_RESET     = 5'h04;
  localparam logic [2:0]  CFG_RESET      = 3'h2;
  // Privilege field codes and coherency codes
  localparam logic [1:0]  KSU_KERNEL     = 2'h0;
  localparam logic [1:0]  KSU_SUPER      = 2'h1;
  localparam logic [2:0]  CCA_UNCACHED   = 3'h2;
  localparam logic [2:0]  CCA_WRITEBACK  = 3'h3;
  localparam logic [2:0]  CCA_UNC_ACCEL  = 3'h7;
  // Exception vector offsets; the extended refill shares the 32-bit entry
  localparam logic [11:0] REFILL_OFS     = 12'h000;
  localparam logic [11:0] XREFILL_OFS    = REFILL_OFS;
  localparam logic [11:0] GENERAL_OFS    = 12'h180;

  // Decoded segment, one-hot
  typedef enum logic [9:0] {
    SEG_USER  = 10'h001,
    SEG_SUPER = 10'h002,
    SEG_CSSEG = 10'h004,
    SEG_KPHYS = 10'h008,
    SEG_KSEG  = 10'h010,
    SEG_CK0   = 10'h020,
    SEG_CK1   = 10'h040,
    SEG_CKS   = 10'h080,
    SEG_CK3   = 10'h100,
    SEG_ERR   = 10'h200
  } seg_e;

  // Outcome of one access, one-hot
  typedef enum logic [4:0] {
    FLT_NONE    = 5'h01,
    FLT_ADDR    = 5'h02,
    FLT_REFILL  = 5'h04,
    FLT_INVALID = 5'h08,
    FLT_MODIFY  = 5'h10
  } fault_e;

  // Page frame record
  typedef struct packed {
    logic [23:0] page_frame_number;
    logic [2:0]  coh;
    logic        dirty;
    logic        valid;
  } frame_s;

  // One translation entry
  typedef struct packed {
    logic [11:0] mask;
    logic [1:0]  region;
    logic [26:0] virtual_page_pair_number;
    logic        global_bit;
    logic [7:0]  asid;
    frame_s      even;
    frame_s      odd;
  } tlb_entry_s;

  // Registered answer to the pipeline
  typedef struct packed {
    logic        done;
    logic [35:0] pa;
    logic [2:0]  coh;
    logic        cached;
    fault_e      fault;
    logic [11:0] vector;
  } xlate_s;
endpackage : vsd_pkg

// ### hw/virtual_segment_decoder.sv
// Added by the designer: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - User address with nonzero bits 63:40 faults
// - Mapped misses use extended refill vector
// - Supervisor only when field 01, levels clear
// - User mode cannot reach supervisor segments
// - Supervisor 00 selects mapped user segment
// - Supervisor 01 selects mapped supervisor segment
// - Supervisor 11 selects separate supervisor window
// - Kernel when field 00 or level set
// - Exceptions enter kernel until return
// - Kernel 00 maps current user space
// - Kernel 01 maps current supervisor space
// - Kernel 10 unmapped, bits 58:36 zero
// - Physical window takes coherency from 61:59
// - Kernel 11 mapped, or compatibility windows
// - First window cached by config, second uncached
// - Third and fourth windows go through buffer
// - Sixty-four entries, numbered staging registers
// - Entry holds mask, region, tag, frames
// - Global only when both frames global
// - Clear valid bit raises invalid fault
// - Clear dirty bit blocks stores
// - Region field compared with bits 63:62
// - Fill and reserved bits read zero
// - Coherency codes 2, 3, 7 decoded
module virtual_segment_decoder #(
  parameter int DEPTH = vsd_pkg::TLB_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  input  wire logic         req_valid,
  input  wire logic [63:0]  req_vaddr,
  input  wire logic         req_store,
  input  wire logic         eret_pulse,
  output vsd_pkg::xlate_s   xlate_out,
  output logic              kernel_mode
);
  // Staging and control registers
  logic [31:0]         mask_reg;     // Page size mask
  logic [63:0]         tag_reg;      // Virtual page tag with identifier
  logic [63:0]         lo0_reg;      // Even page frame
  logic [63:0]         lo1_reg;      // Odd page frame
  logic [4:0]          mode_reg;     // Privilege field and levels
  logic [2:0]          cfg_reg;      // Cached window attribute
  logic [5:0]          last_reg;     // Last segment class and fault summary
  logic [31:0]         rdat_next;    // Read data mux
  vsd_pkg::tlb_entry_s tlb_mem [DEPTH];
  vsd_pkg::xlate_s     xlate_next;
  logic [4:0]          mode_next;

  // Bus decode
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr    = bus_req & wb_we_i;
  wire hit_mask  = wb_adr_i == vsd_pkg::OFS_MASK;
  wire hit_tagl  = wb_adr_i == vsd_pkg::OFS_TAG_LO;
  wire hit_tagh  = wb_adr_i == vsd_pkg::OFS_TAG_HI;
  wire hit_l0l   = wb_adr_i == vsd_pkg::OFS_LO0_LO;
  wire hit_l0h   = wb_adr_i == vsd_pkg::OFS_LO0_HI;
  wire hit_l1l   = wb_adr_i == vsd_pkg::OFS_LO1_LO;
  wire hit_l1h   = wb_adr_i == vsd_pkg::OFS_LO1_HI;
  wire hit_cmd   = wb_adr_i == vsd_pkg::OFS_CMD;
  wire hit_mode  = wb_adr_i == vsd_pkg::OFS_MODE;
  wire hit_cfg   = wb_adr_i == vsd_pkg::OFS_CFG;
  wire hit_res   = wb_adr_i == vsd_pkg::OFS_RESULT;
  // Byte-lane mask from the select lines
  wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Merge written bytes into an old word, keeping only writable bits
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wm);
    merge = ((old & ~lane) | (wb_dat_i & lane)) & wm;
  endfunction : merge

  // Merged words for the short registers, cut to width below
  wire [31:0] cfg_merged  = merge({29'h0, cfg_reg}, 32'h0000_0007);
  wire [31:0] mode_merged = merge({27'h0, mode_reg}, 32'h0000_001F);

  // Entry write command assembled from the staging registers
  wire                entry_wr  = bus_wr & hit_cmd & wb_sel_i[3] & wb_dat_i[vsd_pkg::CMD_WR_BIT];
  wire [5:0]          entry_idx = wb_dat_i[5:0];
  vsd_pkg::tlb_entry_s new_entry;
  assign new_entry.mask       = mask_reg[vsd_pkg::MASK_LSB +: 12];
  assign new_entry.region     = tag_reg[63:62];
  assign new_entry.virtual_page_pair_number       = tag_reg[vsd_pkg::VPN_LSB +: 27];
  assign new_entry.global_bit = lo0_reg[vsd_pkg::G_BIT] & lo1_reg[vsd_pkg::G_BIT];
  assign new_entry.asid       = tag_reg[7:0];
  assign new_entry.even       = {lo0_reg[vsd_pkg::PFN_LSB +: 24], lo0_reg[vsd_pkg::C_LSB +: 3],
                                 lo0_reg[vsd_pkg::D_BIT], lo0_reg[vsd_pkg::V_BIT]};
  assign new_entry.odd        = {lo1_reg[vsd_pkg::PFN_LSB +: 24], lo1_reg[vsd_pkg::C_LSB +: 3],
                                 lo1_reg[vsd_pkg::D_BIT], lo1_reg[vsd_pkg::V_BIT]};

  // Read mux; reserved and fill bits come back as zero
  assign rdat_next = hit_mask ? mask_reg :
                     hit_tagl ? tag_reg[31:0] :
                     hit_tagh ? tag_reg[63:32] :
                     hit_l0l  ? lo0_reg[31:0] :
                     hit_l0h  ? lo0_reg[63:32] :
                     hit_l1l  ? lo1_reg[31:0] :
                     hit_l1h  ? lo1_reg[63:32] :
                     hit_mode ? {27'h0, mode_reg} :
                     hit_cfg  ? {29'h0, cfg_reg} :
                     hit_res  ? {26'h0, last_reg} : 32'h0000_0000;

  // Bus answer: one-cycle ack for every access, unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rdat_next;
    end
  end

  // Staging registers, written through byte lanes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mask_reg <= 32'h0000_0000;
      tag_reg  <= 64'h0;
      lo0_reg  <= 64'h0;
      lo1_reg  <= 64'h0;
      cfg_reg  <= vsd_pkg::CFG_RESET;
    end else if (bus_wr) begin
      if (hit_mask) mask_reg <= merge(mask_reg, vsd_pkg::MASK_WMASK);
      if (hit_tagl) tag_reg[31:0]  <= merge(tag_reg[31:0], vsd_pkg::TAG_WMASK[31:0]);
      if (hit_tagh) tag_reg[63:32] <= merge(tag_reg[63:32], vsd_pkg::TAG_WMASK[63:32]);
      if (hit_l0l)  lo0_reg[31:0]  <= merge(lo0_reg[31:0], vsd_pkg::LO_WMASK[31:0]);
      if (hit_l0h)  lo0_reg[63:32] <= merge(lo0_reg[63:32], vsd_pkg::LO_WMASK[63:32]);
      if (hit_l1l)  lo1_reg[31:0]  <= merge(lo1_reg[31:0], vsd_pkg::LO_WMASK[31:0]);
      if (hit_l1h)  lo1_reg[63:32] <= merge(lo1_reg[63:32], vsd_pkg::LO_WMASK[63:32]);
      if (hit_cfg)  cfg_reg <= cfg_merged[2:0];
    end
  end

  // Translation storage; entries hold no reset value, software fills them
  always_ff @(posedge clk) begin
    if (entry_wr) begin
      tlb_mem[entry_idx] <= new_entry;
    end
  end

  // Privilege decode
  wire [1:0] privilege_mode_field   = mode_reg[vsd_pkg::KSU_LSB +: 2];
  wire       exception_level_bit   = mode_reg[vsd_pkg::EXL_BIT];
  wire       error_level_bit   = mode_reg[vsd_pkg::ERL_BIT];
  wire       is_k  = (privilege_mode_field == vsd_pkg::KSU_KERNEL) | exception_level_bit | error_level_bit;
  wire       is_s  = (privilege_mode_field == vsd_pkg::KSU_SUPER) & ~exception_level_bit & ~error_level_bit;
  wire       is_u  = ~is_k & ~is_s;

  // Address range tests
  wire [1:0] hi2     = req_vaddr[63:62];
  wire       low1t   = req_vaddr[61:40] == 22'h0;
  wire       compat  = &req_vaddr[61:31];
  wire       cs_rng  = (&req_vaddr[63:32]) & (req_vaddr[31:29] == 3'h6);
  wire       ks_rng  = low1t & ~(&req_vaddr[39:31]);
  wire       ph_ok   = req_vaddr[58:36] == 23'h0;

  // Segment selection per privilege
  vsd_pkg::seg_e seg;
  always_comb begin
    seg = vsd_pkg::SEG_ERR;
    if (is_u) begin
      if (req_vaddr[63:40] == 24'h0) seg = vsd_pkg::SEG_USER;
    end else if (is_s) begin
      unique case (hi2)
        2'h0:    if (low1t) seg = vsd_pkg::SEG_USER;
        2'h1:    if (low1t) seg = vsd_pkg::SEG_SUPER;
        2'h3:    if (cs_rng) seg = vsd_pkg::SEG_CSSEG;
        default: seg = vsd_pkg::SEG_ERR;
      endcase
    end else begin
      unique case (hi2)
        2'h0: if (low1t) seg = vsd_pkg::SEG_USER;
        2'h1: if (low1t) seg = vsd_pkg::SEG_SUPER;
        2'h2: if (ph_ok) seg = vsd_pkg::SEG_KPHYS;
        2'h3: begin
          if (compat) begin
            unique case (req_vaddr[30:29])
              2'h0: seg = vsd_pkg::SEG_CK0;
              2'h1: seg = vsd_pkg::SEG_CK1;
              2'h2: seg = vsd_pkg::SEG_CKS;
              2'h3: seg = vsd_pkg::SEG_CK3;
            endcase
          end else if (ks_rng) begin
            seg = vsd_pkg::SEG_KSEG;
          end
        end
      endcase
    end
  end

  wire mapped = seg inside {vsd_pkg::SEG_USER, vsd_pkg::SEG_SUPER, vsd_pkg::SEG_CSSEG,
                            vsd_pkg::SEG_KSEG, vsd_pkg::SEG_CKS, vsd_pkg::SEG_CK3};

  // Associative match, one comparator per entry
  logic [DEPTH-1:0]    hit_vec;
  logic [DEPTH*$bits(vsd_pkg::tlb_entry_s)-1:0] pick_vec;
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_match
      wire [26:0] cmpm = ~{15'h0, tlb_mem[gi].mask};
      assign hit_vec[gi] = (tlb_mem[gi].region == hi2) &
                           (((tlb_mem[gi].virtual_page_pair_number ^ req_vaddr[39:13]) & cmpm) == 27'h0) &
                           (tlb_mem[gi].global_bit | (tlb_mem[gi].asid == tag_reg[7:0]));
      assign pick_vec[gi*$bits(vsd_pkg::tlb_entry_s) +: $bits(vsd_pkg::tlb_entry_s)] =
             hit_vec[gi] ? tlb_mem[gi] : '0;
    end
  endgenerate

  // Multiple hits are undefined; the OR of matching entries is taken
  vsd_pkg::tlb_entry_s hit_e;
  always_comb begin
    hit_e = '0;
    for (int i = 0; i < DEPTH; i++) begin
      hit_e = hit_e | pick_vec[i*$bits(vsd_pkg::tlb_entry_s) +: $bits(vsd_pkg::tlb_entry_s)];
    end
  end

  // Even/odd select bit sits just above the masked offset
  wire [12:0]   selm  = {hit_e.mask, 1'b1};
  wire          odd   = |(req_vaddr[24:12] & selm & ~(selm >> 1));
  vsd_pkg::frame_s fr;
  assign fr = odd ? hit_e.odd : hit_e.even;
  wire [23:0]   pg_pa = (fr.page_frame_number & ~{12'h0, hit_e.mask}) | (req_vaddr[35:12] & {12'h0, hit_e.mask});
  wire          any_hit = |hit_vec;

  // Result of one access
  always_comb begin
    xlate_next        = '0;
    xlate_next.done   = req_valid;
    xlate_next.fault  = vsd_pkg::FLT_NONE;
    xlate_next.vector = vsd_pkg::GENERAL_OFS;
    if (seg == vsd_pkg::SEG_ERR) begin
      xlate_next.fault = vsd_pkg::FLT_ADDR;
    end else if (seg == vsd_pkg::SEG_KPHYS) begin
      xlate_next.pa  = req_vaddr[35:0];
      xlate_next.coh = req_vaddr[61:59];
    end else if (seg == vsd_pkg::SEG_CK0) begin
      xlate_next.pa  = {7'h00, req_vaddr[28:0]};
      xlate_next.coh = cfg_reg;
    end else if (seg == vsd_pkg::SEG_CK1) begin
      xlate_next.pa  = {7'h00, req_vaddr[28:0]};
      xlate_next.coh = vsd_pkg::CCA_UNCACHED;
    end else if (mapped) begin
      xlate_next.pa  = {pg_pa, req_vaddr[11:0]};
      xlate_next.coh = fr.coh;
      if (!any_hit) begin
        xlate_next.fault  = vsd_pkg::FLT_REFILL;
        xlate_next.vector = vsd_pkg::XREFILL_OFS;
      end else if (!fr.valid) begin
        xlate_next.fault = vsd_pkg::FLT_INVALID;
      end else if (req_store & ~fr.dirty) begin
        xlate_next.fault = vsd_pkg::FLT_MODIFY;
      end
    end
    if (xlate_next.fault != vsd_pkg::FLT_NONE) begin
      xlate_next.pa  = 36'h0;
      xlate_next.coh = 3'h0;
    end else begin
      xlate_next.vector = 12'h000;
    end
    // Writeback is the only cacheable code; 2 and 7 are uncached
    xlate_next.cached = (xlate_next.coh == vsd_pkg::CCA_WRITEBACK);
    if (!req_valid) begin
      xlate_next = '0;
      xlate_next.fault = vsd_pkg::FLT_NONE;
    end
  end

  wire exc_now = req_valid & (xlate_next.fault != vsd_pkg::FLT_NONE);

  // Mode register: software writes, exceptions set the level, return clears it
  always_comb begin
    mode_next = mode_reg;
    if (bus_wr & hit_mode) mode_next = mode_merged[4:0];
    if (eret_pulse) begin
      if (mode_next[vsd_pkg::ERL_BIT]) mode_next[vsd_pkg::ERL_BIT] = 1'b0;
      else mode_next[vsd_pkg::EXL_BIT] = 1'b0;
    end
    if (exc_now) mode_next[vsd_pkg::EXL_BIT] = 1'b1;
  end

  // Registered outputs toward the pipeline
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_reg    <= vsd_pkg::MODE_RESET;
      xlate_out   <= '{done: 1'b0, pa: 36'h0, coh: 3'h0, cached: 1'b0,
                       fault: vsd_pkg::FLT_NONE, vector: 12'h000};
      kernel_mode <= 1'b1;
      last_reg    <= 6'h00;
    end else begin
      mode_reg    <= mode_next;
      xlate_out   <= xlate_next;
      kernel_mode <= (mode_next[vsd_pkg::KSU_LSB +: 2] == vsd_pkg::KSU_KERNEL) |
                     mode_next[vsd_pkg::EXL_BIT] | mode_next[vsd_pkg::ERL_BIT];
      if (req_valid) last_reg <= {mapped, xlate_next.fault};
    end
  end

  // Checks on the decoder
  a_user_high_err: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & is_u & (req_vaddr[63:40] != 24'h0) |=> xlate_out.fault == vsd_pkg::FLT_ADDR)
    else $error("user high address not faulted");
  a_refill_vec: assert property (@(posedge clk) disable iff (!rst_b)
    xlate_out.fault == vsd_pkg::FLT_REFILL |-> xlate_out.vector == vsd_pkg::REFILL_OFS)
    else $error("refill vector wrong");
  a_super_csseg: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & is_s & (req_vaddr[63:29] == 35'h7_FFFF_FFFE) |-> seg == vsd_pkg::SEG_CSSEG)
    else $error("separate supervisor window missed");
  a_super_hole: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & is_s & (hi2 == 2'h2) |=> xlate_out.fault == vsd_pkg::FLT_ADDR)
    else $error("supervisor hole not faulted");
  a_exc_kernel: assert property (@(posedge clk) disable iff (!rst_b)
    exc_now & ~(bus_wr & hit_mode) |=> kernel_mode & mode_reg[vsd_pkg::EXL_BIT])
    else $error("exception did not enter kernel");
  a_phys_map: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & is_k & (hi2 == 2'h2) & ph_ok |=>
      (xlate_out.pa == $past(req_vaddr[35:0])) & (xlate_out.coh == $past(req_vaddr[61:59])))
    else $error("physical window translation wrong");
  a_ck1_uncached: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & (seg == vsd_pkg::SEG_CK1) |=> xlate_out.coh == vsd_pkg::CCA_UNCACHED && !xlate_out.cached)
    else $error("uncached window cached");
  a_global_both: assert property (@(posedge clk) disable iff (!rst_b)
    entry_wr & ~(lo0_reg[0] & lo1_reg[0]) |=> !tlb_mem[$past(entry_idx)].global_bit)
    else $error("global set from one frame");
  a_store_prot: assert property (@(posedge clk) disable iff (!rst_b)
    req_valid & req_store & mapped & any_hit & fr.valid & ~fr.dirty |=>
      xlate_out.fault == vsd_pkg::FLT_MODIFY)
    else $error("store to clean page allowed");
  a_fill_zero: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o & $past(hit_tagh) |-> wb_dat_o[29:8] == 22'h0)
    else $error("fill bits read nonzero");
endmodule : virtual_segment_decoder

// ### test/pipe_model.sv
`timescale 1ns/100ps
// Stand-in for the fetch and load/store pipeline: one access per call
module pipe_model (
  input  wire logic        clk,
  output logic             req_valid,
  output logic [63:0]      req_vaddr,
  output logic             req_store
);
  // Idle values at time zero
  initial begin
    req_valid = 1'b0;
    req_vaddr = 64'h0;
    req_store = 1'b0;
  end

  // Raise the request for exactly one edge, then scramble the address so a stale value is never reused
  task automatic access(input logic [63:0] va, input logic st);
    @(posedge clk);
    req_valid <= 1'b1;
    req_vaddr <= va;
    req_store <= st;
    @(posedge clk);
    req_valid <= 1'b0;
    req_vaddr <= ~va;
    req_store <= ~st;
  endtask : access
endmodule : pipe_model

// ### test/virtual_segment_decoder_test.sv
`timescale 1ns/100ps
// Register and segment decode checks through the bus and the pipeline model
module virtual_segment_decoder_test;
  logic            clk;      // Core clock
  logic            rst_b;    // Synchronous reset, active low
  logic            cyc;      // Bus cycle
  logic            stb;      // Bus strobe
  logic            we;       // Bus direction
  logic [7:0]      adr;      // Bus address
  logic [3:0]      sel;      // Byte lanes
  logic [31:0]     dat_w;    // Write data
  logic [31:0]     wb_dat_o; // Read data
  logic            wb_ack_o; // Bus answer
  logic            eret_pulse;
  logic            req_valid;
  logic [63:0]     req_vaddr;
  logic            req_store;
  logic            kernel_mode;
  logic [31:0]     rd;       // Last read word
  vsd_pkg::xlate_s xo;       // Pipeline answer
  int              mismatches;
  int              checked;

  // Clock of 40 ns period
  always #20 clk = ~clk;

  pipe_model pm (.clk(clk), .req_valid(req_valid), .req_vaddr(req_vaddr), .req_store(req_store));

  virtual_segment_decoder #(.DEPTH(vsd_pkg::TLB_DEPTH)) dut (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .req_valid(req_valid), .req_vaddr(req_vaddr), .req_store(req_store), .eret_pulse(eret_pulse),
    .xlate_out(xo), .kernel_mode(kernel_mode));

  // Compare one value and count it
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(1, 0);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  // Write the mode register and check the resulting privilege level
  task automatic setm(input logic [31:0] m, input logic k);
    wb(1, vsd_pkg::OFS_MODE, m);
    @(negedge clk);
    chk(kernel_mode, k);
  endtask : setm

  // One pipeline access; the vector follows from the fault kind
  task automatic acc(input logic [63:0] va, input logic st, input vsd_pkg::fault_e f,
                     input logic [35:0] pa, input logic [2:0] coh);
    pm.access(va, st);
    @(negedge clk);
    chk(xo.done, 1);
    chk(xo.fault, f);
    chk(xo.vector, (f == vsd_pkg::FLT_NONE || f == vsd_pkg::FLT_REFILL) ? 12'h000 : vsd_pkg::GENERAL_OFS);
    if (f == vsd_pkg::FLT_NONE) begin
      chk(xo.pa, pa);
      chk(xo.coh, coh);
      chk(xo.cached, coh == vsd_pkg::CCA_WRITEBACK);
    end
  endtask : acc

  // Print counts and the verdict, then stop
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Watchdog well beyond the expected run length
  initial begin
    #(40 * 20000);
    mismatches++;
    end_sim;
  end

  // Main sequence
  initial begin
    clk = 0; rst_b = 0; cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'hF; dat_w = 32'h0; eret_pulse = 0;
    mismatches = 0; checked = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wb(0, vsd_pkg::OFS_MODE, 0); chk(rd, 32'h0000_0004);
    wb(0, vsd_pkg::OFS_CFG, 0); chk(rd, 32'h0000_0002);
    wb(0, 8'h30, 0); chk(rd, 32'h0);
    chk(kernel_mode, 1);
    // Fill every entry with a harmless non-matching record
    wb(1, vsd_pkg::OFS_TAG_LO, 32'hFFFF_E000);
    wb(1, vsd_pkg::OFS_TAG_HI, 32'hFFFF_FFFF);
    wb(0, vsd_pkg::OFS_TAG_HI, 0); chk(rd, 32'hC000_00FF);
    wb(1, vsd_pkg::OFS_LO0_LO, 0); wb(1, vsd_pkg::OFS_LO1_LO, 0);
    for (int i = 0; i < vsd_pkg::TLB_DEPTH; i++) wb(1, vsd_pkg::OFS_CMD, 32'h8000_0000 | i);
    // Entry 5: user pair at 0x2000, even clean and valid, odd dirty and invalid
    wb(1, vsd_pkg::OFS_MASK, 0); wb(1, vsd_pkg::OFS_TAG_LO, 32'h0000_2012); wb(1, vsd_pkg::OFS_TAG_HI, 0);
    wb(1, vsd_pkg::OFS_LO0_LO, 32'h0002_AF1A); wb(1, vsd_pkg::OFS_LO1_LO, 32'h0003_7BD4);
    wb(0, vsd_pkg::OFS_LO1_LO, 0); chk(rd, 32'h0003_7BD4);
    wb(1, vsd_pkg::OFS_CMD, 32'h8000_0005);
    $display("Test registers done");
    acc(64'h2345, 0, vsd_pkg::FLT_NONE, 36'hABC345, 3'h3);
    acc(64'h9800_0000_1234_5678, 0, vsd_pkg::FLT_NONE, 36'h0_1234_5678, 3'h3);
    acc(64'h8000_1000_0000_0000, 0, vsd_pkg::FLT_ADDR, 0, 0);
    acc(64'hFFFF_FFFF_A000_0010, 0, vsd_pkg::FLT_NONE, 36'h10, 3'h2);
    acc(64'hFFFF_FFFF_8000_0020, 0, vsd_pkg::FLT_NONE, 36'h20, 3'h2);
    wb(1, vsd_pkg::OFS_CFG, 32'h3);
    acc(64'hFFFF_FFFF_8000_0020, 0, vsd_pkg::FLT_NONE, 36'h20, 3'h3);
    acc(64'hFFFF_FFFF_E000_0000, 0, vsd_pkg::FLT_REFILL, 0, 0);
    $display("Test kernel done");
    setm(32'h10, 0);
    acc(64'h0000_0100_0000_0000, 0, vsd_pkg::FLT_ADDR, 0, 0);
    chk(kernel_mode, 1);
    @(posedge clk); eret_pulse <= 1'b1;
    @(posedge clk); eret_pulse <= 1'b0;
    @(negedge clk); chk(kernel_mode, 0);
    acc(64'h4000_0000_0000_2000, 0, vsd_pkg::FLT_ADDR, 0, 0);
    setm(32'h10, 0);
    acc(64'h2345, 1, vsd_pkg::FLT_MODIFY, 0, 0);
    setm(32'h10, 0);
    acc(64'h3000, 0, vsd_pkg::FLT_INVALID, 0, 0);
    setm(32'h10, 0);
    acc(64'h6000, 0, vsd_pkg::FLT_REFILL, 0, 0);
    wb(0, vsd_pkg::OFS_RESULT, 0); chk(rd, 32'h0000_0024);
    $display("Test user done");
    setm(32'h08, 0);
    acc(64'h2345, 0, vsd_pkg::FLT_NONE, 36'hABC345, 3'h3);
    acc(64'h4000_0000_0000_2000, 0, vsd_pkg::FLT_REFILL, 0, 0);
    setm(32'h08, 0);
    acc(64'h4000_0100_0000_0000, 0, vsd_pkg::FLT_ADDR, 0, 0);
    setm(32'h08, 0);
    acc(64'hFFFF_FFFF_C000_0000, 0, vsd_pkg::FLT_REFILL, 0, 0);
    setm(32'h08, 0);
    acc(64'hFFFF_FFFF_E000_0000, 0, vsd_pkg::FLT_ADDR, 0, 0);
    setm(32'h0A, 1);
    $display("Test supervisor done");
    end_sim;
  end
endmodule : virtual_segment_decoder_test
